// ===== iwd_decoder.sv
// Instruction word decoder and four-period sequencer with read-modify-write datapath
`timescale 1ns/1ps
`include "iwd_regs.svh"
module iwd_decoder (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Program memory
    output logic [`IWD_PC_W-1:0]         progAddr,
    input  wire logic [`IWD_WORD_W-1:0]  instrWord,
    // Register file
    output logic [6:0]                   regAddr,
    output logic                         regRdEn,
    input  wire logic [7:0]              regRdData,
    output logic                         regWrEn,
    output logic [7:0]                   regWrData,
    // Accumulator and status
    output logic [7:0]                   wReg,
    output logic                         carry,
    output logic                         digitCarry,
    output logic                         zero,
    // Peripheral side effects
    input  wire logic                    timerPrescAssigned,
    output logic                         pinChangeClear,
    output logic                         prescalerClear,
    output logic                         watchdogClear,
    output logic                         sleepRequest,
    output logic                         interruptReturn,
    output logic [3:0]                   phase
);

    // ======================================================
    // Shared arithmetic: returns {carry, digit carry, sum}
    function automatic logic [9:0] addc(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        return {hi[4], lo[4], hi[3:0], lo[3:0]};
    endfunction : addc

    // ======================================================
    // State
    iwd_pkg::iwd_phase_e           ph;
    iwd_pkg::iwd_phase_e           next_ph;
    logic [`IWD_WORD_W-1:0]        ir;
    logic [`IWD_WORD_W-1:0]        next_ir;
    logic [`IWD_PC_W-1:0]          pc;
    logic [`IWD_PC_W-1:0]          next_pc;
    logic [`IWD_PC_W-1:0]          next_progAddr;
    logic                          bubble;
    logic                          next_bubble;
    logic [`IWD_SP_W-1:0]          sp;
    logic [`IWD_SP_W-1:0]          next_sp;
    logic [`IWD_PC_W-1:0]          stack [`IWD_STACK_D];
    logic                          stackPush;
    logic [6:0]                    next_regAddr;
    logic                          next_regRdEn;
    logic                          next_regWrEn;
    logic [7:0]                    next_regWrData;
    logic [7:0]                    next_wReg;
    logic                          next_carry;
    logic                          next_digitCarry;
    logic                          next_zero;
    logic                          next_pinChangeClear;
    logic                          next_prescalerClear;
    logic                          next_watchdogClear;
    logic                          next_sleepRequest;
    logic                          next_interruptReturn;

    iwd_dec_if dec ();

    iwd_field_decode u_fields (
        .ir  (ir),
        .dec (dec)
    );

    // ======================================================
    // Next-state logic
    always_comb begin
        logic [9:0] s;
        logic [7:0] res;
        logic [7:0] mask;
        logic       updZ;
        logic       skip;
        logic       jump;
        logic [`IWD_PC_W-1:0] target;
        s      = 10'h000;
        res    = 8'h00;
        mask   = (dec.fmt == iwd_pkg::FMT_BIT) ? (8'h01 << dec.bitSel) : 8'h00;
        updZ   = 1'b0;
        skip   = 1'b0;
        jump   = 1'b0;
        target = pc;
        next_ph              = ph;
        next_ir              = ir;
        next_pc              = pc;
        next_progAddr        = progAddr;
        next_bubble          = bubble;
        next_sp              = sp;
        stackPush            = 1'b0;
        next_regAddr         = regAddr;
        next_regRdEn         = 1'b0;
        next_regWrEn         = 1'b0;
        next_regWrData       = regWrData;
        next_wReg            = wReg;
        next_carry           = carry;
        next_digitCarry      = digitCarry;
        next_zero            = zero;
        next_pinChangeClear  = 1'b0;
        next_prescalerClear  = 1'b0;
        next_watchdogClear   = 1'b0;
        next_sleepRequest    = 1'b0;
        next_interruptReturn = 1'b0;
        case (ph)
            iwd_pkg::PH_Q1: begin
                next_ph = iwd_pkg::PH_Q2;
                next_ir = bubble ? `IWD_NOP_WORD : instrWord;
                next_pc = progAddr + `IWD_PC_W'(1);
            end
            iwd_pkg::PH_Q2: begin
                next_ph      = iwd_pkg::PH_Q3;
                next_regAddr = dec.fileAddr;
                next_regRdEn = dec.namesFile;
                next_pinChangeClear = dec.namesFile &&
                                      dec.fileAddr == `IWD_PORT_ADDR;
            end
            iwd_pkg::PH_Q3: begin
                next_ph = iwd_pkg::PH_Q4;
            end
            iwd_pkg::PH_Q4: begin
                next_ph = iwd_pkg::PH_Q1;
                case (dec.op)
                    iwd_pkg::OP_MOVWF: res = wReg;
                    iwd_pkg::OP_CLRW, iwd_pkg::OP_CLRF: begin
                        res  = 8'h00;
                        updZ = 1'b1;
                    end
                    iwd_pkg::OP_ADDF, iwd_pkg::OP_SUBF, iwd_pkg::OP_ADDL,
                    iwd_pkg::OP_SUBL: begin
                        case (dec.op)
                            iwd_pkg::OP_ADDF: s = addc(regRdData, wReg, 1'b0);
                            iwd_pkg::OP_SUBF: s = addc(regRdData, ~wReg, 1'b1);
                            iwd_pkg::OP_ADDL: s = addc(dec.lit8, wReg, 1'b0);
                            default:          s = addc(dec.lit8, ~wReg, 1'b1);
                        endcase
                        res             = s[7:0];
                        next_carry      = s[9];
                        next_digitCarry = s[8];
                        updZ            = 1'b1;
                    end
                    iwd_pkg::OP_IORF: {res, updZ} = {regRdData | wReg, 1'b1};
                    iwd_pkg::OP_ANDF: {res, updZ} = {regRdData & wReg, 1'b1};
                    iwd_pkg::OP_XORF: {res, updZ} = {regRdData ^ wReg, 1'b1};
                    iwd_pkg::OP_IORL: {res, updZ} = {dec.lit8 | wReg, 1'b1};
                    iwd_pkg::OP_ANDL: {res, updZ} = {dec.lit8 & wReg, 1'b1};
                    iwd_pkg::OP_XORL: {res, updZ} = {dec.lit8 ^ wReg, 1'b1};
                    iwd_pkg::OP_MOVF: {res, updZ} = {regRdData, 1'b1};
                    iwd_pkg::OP_COMF: {res, updZ} = {~regRdData, 1'b1};
                    iwd_pkg::OP_DECF: {res, updZ} = {regRdData - 8'h01, 1'b1};
                    iwd_pkg::OP_INCF: {res, updZ} = {regRdData + 8'h01, 1'b1};
                    iwd_pkg::OP_DECSZ: begin
                        res  = regRdData - 8'h01;
                        skip = (res == 8'h00);
                    end
                    iwd_pkg::OP_INCSZ: begin
                        res  = regRdData + 8'h01;
                        skip = (res == 8'h00);
                    end
                    iwd_pkg::OP_RLF: {next_carry, res} = {regRdData, carry};
                    iwd_pkg::OP_RRF: {res, next_carry} = {carry, regRdData};
                    iwd_pkg::OP_SWAPF: res = {regRdData[3:0], regRdData[7:4]};
                    iwd_pkg::OP_BCLR: res = regRdData & ~mask;
                    iwd_pkg::OP_BSET: res = regRdData | mask;
                    iwd_pkg::OP_BTSC: skip = (regRdData & mask) == 8'h00;
                    iwd_pkg::OP_BTSS: skip = (regRdData & mask) != 8'h00;
                    iwd_pkg::OP_MOVL: res = dec.lit8;
                    iwd_pkg::OP_CALL, iwd_pkg::OP_GOTO: begin
                        jump      = 1'b1;
                        target    = dec.lit11;
                        stackPush = (dec.op == iwd_pkg::OP_CALL);
                    end
                    iwd_pkg::OP_RET, iwd_pkg::OP_RETI, iwd_pkg::OP_RETL: begin
                        res                  = dec.lit8;
                        jump                 = 1'b1;
                        target               = stack[sp - `IWD_SP_W'(1)];
                        next_sp              = sp - `IWD_SP_W'(1);
                        next_interruptReturn = (dec.op == iwd_pkg::OP_RETI);
                    end
                    iwd_pkg::OP_WDTCLR: next_watchdogClear = 1'b1;
                    iwd_pkg::OP_SLEEP:  next_sleepRequest  = 1'b1;
                    default:            res = 8'h00;
                endcase
                if (stackPush) begin
                    next_sp = sp + `IWD_SP_W'(1);
                end
                if (updZ) begin
                    next_zero = (res == 8'h00);
                end
                if (dec.writes && dec.toFile) begin
                    next_regWrEn        = 1'b1;
                    next_regWrData      = res;
                    next_prescalerClear = timerPrescAssigned &&
                                          regAddr == `IWD_TIMER_ADDR;
                end else if (dec.writes) begin
                    next_wReg = res;
                end
                if (bubble) begin
                    next_bubble = 1'b0;
                end else if (jump) begin
                    next_progAddr = target;
                    next_bubble   = 1'b1;
                end else if (skip) begin
                    next_progAddr = pc + `IWD_PC_W'(1);
                    next_bubble   = 1'b1;
                end else begin
                    next_progAddr = pc;
                end
            end
            default: next_ph = iwd_pkg::PH_Q1;
        endcase
    end

    // ======================================================
    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ph              <= iwd_pkg::PH_Q1;
            ir              <= `IWD_NOP_WORD;
            pc              <= `IWD_RESET_PC;
            progAddr        <= `IWD_RESET_PC;
            bubble          <= 1'b0;
            sp              <= '0;
            regAddr         <= 7'h00;
            regRdEn         <= 1'b0;
            regWrEn         <= 1'b0;
            regWrData       <= 8'h00;
            wReg            <= 8'h00;
            carry           <= 1'b0;
            digitCarry      <= 1'b0;
            zero            <= 1'b0;
            pinChangeClear  <= 1'b0;
            prescalerClear  <= 1'b0;
            watchdogClear   <= 1'b0;
            sleepRequest    <= 1'b0;
            interruptReturn <= 1'b0;
        end else begin
            ph              <= next_ph;
            ir              <= next_ir;
            pc              <= next_pc;
            progAddr        <= next_progAddr;
            bubble          <= next_bubble;
            sp              <= next_sp;
            regAddr         <= next_regAddr;
            regRdEn         <= next_regRdEn;
            regWrEn         <= next_regWrEn;
            regWrData       <= next_regWrData;
            wReg            <= next_wReg;
            carry           <= next_carry;
            digitCarry      <= next_digitCarry;
            zero            <= next_zero;
            pinChangeClear  <= next_pinChangeClear;
            prescalerClear  <= next_prescalerClear;
            watchdogClear   <= next_watchdogClear;
            sleepRequest    <= next_sleepRequest;
            interruptReturn <= next_interruptReturn;
        end
    end

    // ======================================================
    // Return stack, wraps after eight levels
    always_ff @(posedge clk) begin
        if (!rst && stackPush) begin
            stack[sp] <= pc;
        end
    end

    assign phase = ph;

endmodule : iwd_decoder

// ===== iwd_regs.svh
// Constants for the instruction word decoder: field positions, codes, sizes
`ifndef IWD_REGS_SVH
`define IWD_REGS_SVH

// ==========================================================
// Word and field layout
`define IWD_WORD_W      14
`define IWD_FMT_MSB     13
`define IWD_FMT_LSB     12
`define IWD_JUMP_BIT    11
`define IWD_DEST_BIT    7
`define IWD_FILE_MSB    6
`define IWD_BIT_MSB     9
`define IWD_BIT_LSB     7
`define IWD_LIT8_MSB    7
`define IWD_LIT11_MSB   10

// ==========================================================
// Sizes and reset values
`define IWD_PC_W        11
`define IWD_STACK_D     8
`define IWD_SP_W        3
`define IWD_RESET_PC    11'h000
`define IWD_NOP_WORD    14'h0000

// ==========================================================
// Special file register addresses
`define IWD_PORT_ADDR   7'h10
`define IWD_TIMER_ADDR  7'h11

`endif

// ===== iwd_pkg.sv
// Types shared by the instruction word decoder modules
package iwd_pkg;

    // ======================================================
    // Instruction format classes
    typedef enum logic [1:0] {
        FMT_BYTE = 2'h0,
        FMT_BIT  = 2'h1,
        FMT_CTRL = 2'h2
    } iwd_fmt_e;

    // ======================================================
    // Decoded operations
    typedef enum logic [5:0] {
        OP_NOP, OP_MOVWF, OP_CLRW, OP_CLRF, OP_SUBF, OP_DECF, OP_IORF,
        OP_ANDF, OP_XORF, OP_ADDF, OP_MOVF, OP_COMF, OP_INCF, OP_DECSZ,
        OP_RRF, OP_RLF, OP_SWAPF, OP_INCSZ, OP_BCLR, OP_BSET, OP_BTSC,
        OP_BTSS, OP_CALL, OP_GOTO, OP_MOVL, OP_RETL, OP_SUBL, OP_ADDL,
        OP_IORL, OP_ANDL, OP_XORL, OP_RET, OP_RETI, OP_WDTCLR, OP_SLEEP
    } iwd_op_e;

    // ======================================================
    // Oscillator periods within one instruction cycle
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } iwd_phase_e;

endpackage : iwd_pkg

// ===== iwd_dec_if.sv
// Decoded instruction fields passed from the field decoder to the sequencer
`timescale 1ns/1ps
interface iwd_dec_if;
    iwd_pkg::iwd_op_e  op;
    iwd_pkg::iwd_fmt_e fmt;
    logic [6:0]        fileAddr;
    logic [2:0]        bitSel;
    logic [7:0]        lit8;
    logic [10:0]       lit11;
    logic              namesFile;
    logic              writes;
    logic              toFile;

    modport src (output op, fmt, fileAddr, bitSel, lit8, lit11, namesFile, writes, toFile);
    modport dst (input  op, fmt, fileAddr, bitSel, lit8, lit11, namesFile, writes, toFile);
endinterface : iwd_dec_if

// ===== iwd_field_decode.sv
// Combinational split of a 14-bit instruction word into format, operation and operands
`timescale 1ns/1ps
`include "iwd_regs.svh"
module iwd_field_decode (
    // Instruction word
    input wire logic [`IWD_WORD_W-1:0] ir,
    // Decoded fields
    iwd_dec_if.src                     dec
);

    // ======================================================
    // Operand fields
    always_comb begin
        dec.fileAddr = ir[`IWD_FILE_MSB:0];
        dec.bitSel   = ir[`IWD_BIT_MSB:`IWD_BIT_LSB];
        dec.lit8     = ir[`IWD_LIT8_MSB:0];
        dec.lit11    = ir[`IWD_LIT11_MSB:0];
        dec.fmt      = iwd_pkg::iwd_fmt_e'(ir[`IWD_FMT_MSB:`IWD_FMT_LSB]);
        if (ir[`IWD_FMT_MSB]) begin
            dec.fmt = iwd_pkg::FMT_CTRL;
        end
    end

    // ======================================================
    // Operation select, don't-care positions masked by casez
    always_comb begin
        dec.op        = iwd_pkg::OP_NOP;
        dec.namesFile = 1'b0;
        dec.writes    = 1'b0;
        dec.toFile    = ir[`IWD_DEST_BIT];
        casez (ir)
            14'b00_0000_1???_????: dec.op = iwd_pkg::OP_MOVWF;
            14'b00_0000_0000_1000: dec.op = iwd_pkg::OP_RET;
            14'b00_0000_0000_1001: dec.op = iwd_pkg::OP_RETI;
            14'b00_0000_0110_0011: dec.op = iwd_pkg::OP_SLEEP;
            14'b00_0000_0110_0100: dec.op = iwd_pkg::OP_WDTCLR;
            14'b00_0001_1???_????: dec.op = iwd_pkg::OP_CLRF;
            14'b00_0001_0???_????: dec.op = iwd_pkg::OP_CLRW;
            14'b00_0010_????_????: dec.op = iwd_pkg::OP_SUBF;
            14'b00_0011_????_????: dec.op = iwd_pkg::OP_DECF;
            14'b00_0100_????_????: dec.op = iwd_pkg::OP_IORF;
            14'b00_0101_????_????: dec.op = iwd_pkg::OP_ANDF;
            14'b00_0110_????_????: dec.op = iwd_pkg::OP_XORF;
            14'b00_0111_????_????: dec.op = iwd_pkg::OP_ADDF;
            14'b00_1000_????_????: dec.op = iwd_pkg::OP_MOVF;
            14'b00_1001_????_????: dec.op = iwd_pkg::OP_COMF;
            14'b00_1010_????_????: dec.op = iwd_pkg::OP_INCF;
            14'b00_1011_????_????: dec.op = iwd_pkg::OP_DECSZ;
            14'b00_1100_????_????: dec.op = iwd_pkg::OP_RRF;
            14'b00_1101_????_????: dec.op = iwd_pkg::OP_RLF;
            14'b00_1110_????_????: dec.op = iwd_pkg::OP_SWAPF;
            14'b00_1111_????_????: dec.op = iwd_pkg::OP_INCSZ;
            14'b01_00??_????_????: dec.op = iwd_pkg::OP_BCLR;
            14'b01_01??_????_????: dec.op = iwd_pkg::OP_BSET;
            14'b01_10??_????_????: dec.op = iwd_pkg::OP_BTSC;
            14'b01_11??_????_????: dec.op = iwd_pkg::OP_BTSS;
            14'b10_0???_????_????: dec.op = iwd_pkg::OP_CALL;
            14'b10_1???_????_????: dec.op = iwd_pkg::OP_GOTO;
            14'b11_00??_????_????: dec.op = iwd_pkg::OP_MOVL;
            14'b11_01??_????_????: dec.op = iwd_pkg::OP_RETL;
            14'b11_1000_????_????: dec.op = iwd_pkg::OP_IORL;
            14'b11_1001_????_????: dec.op = iwd_pkg::OP_ANDL;
            14'b11_1010_????_????: dec.op = iwd_pkg::OP_XORL;
            14'b11_110?_????_????: dec.op = iwd_pkg::OP_SUBL;
            14'b11_111?_????_????: dec.op = iwd_pkg::OP_ADDL;
            default:               dec.op = iwd_pkg::OP_NOP;
        endcase
        case (dec.op)
            iwd_pkg::OP_MOVWF, iwd_pkg::OP_CLRF, iwd_pkg::OP_BCLR, iwd_pkg::OP_BSET: begin
                dec.namesFile = 1'b1;
                dec.writes    = 1'b1;
                dec.toFile    = 1'b1;
            end
            iwd_pkg::OP_BTSC, iwd_pkg::OP_BTSS: begin
                dec.namesFile = 1'b1;
            end
            iwd_pkg::OP_NOP, iwd_pkg::OP_RET, iwd_pkg::OP_RETI, iwd_pkg::OP_SLEEP,
            iwd_pkg::OP_WDTCLR, iwd_pkg::OP_CALL, iwd_pkg::OP_GOTO: begin
                dec.toFile    = 1'b0;
            end
            iwd_pkg::OP_CLRW, iwd_pkg::OP_MOVL, iwd_pkg::OP_RETL, iwd_pkg::OP_SUBL,
            iwd_pkg::OP_ADDL, iwd_pkg::OP_IORL, iwd_pkg::OP_ANDL, iwd_pkg::OP_XORL: begin
                dec.writes    = 1'b1;
                dec.toFile    = 1'b0;
            end
            default: begin
                dec.namesFile = 1'b1;
                dec.writes    = 1'b1;
            end
        endcase
    end

endmodule : iwd_field_decode

// ===== iwd_decoder_sva.sv
// Assertion checker for the instruction word decoder
`timescale 1ns/1ps
`include "iwd_regs.svh"
module iwd_decoder_sva (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Observed inputs
    input wire logic        timerPrescAssigned,
    // Observed outputs
    input wire logic [10:0] progAddr,
    input wire logic [6:0]  regAddr,
    input wire logic        regRdEn,
    input wire logic        regWrEn,
    input wire logic        pinChangeClear,
    input wire logic        prescalerClear,
    input wire logic        watchdogClear,
    input wire logic [3:0]  phase
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Phase steps
    sequence s_late;
        phase == 4'h2 ##1 phase == 4'h4 ##1 phase == 4'h8;
    endsequence
    a_phase_cycle: assert property (phase == 4'h1 |=> s_late ##1 phase == 4'h1)
        else $error("phase order broken");
    a_pc_hold: assert property (phase != 4'h8 |=> $stable(progAddr))
        else $error("fetch address moved mid cycle");
    a_read_q3: assert property (regRdEn |-> phase == 4'h4)
        else $error("read pulse outside third period");
    a_write_after_read: assert property (regWrEn |-> phase == 4'h1 && $past(regRdEn, 2))
        else $error("write without preceding read");
    a_addr_hold: assert property (phase != 4'h2 |=> $stable(regAddr))
        else $error("file address moved");
    a_port_clear: assert property (regRdEn && regAddr == `IWD_PORT_ADDR |-> pinChangeClear)
        else $error("port read without clear");
    a_clear_cause: assert property (pinChangeClear |-> regRdEn && regAddr == `IWD_PORT_ADDR)
        else $error("stray pin change clear");
    a_presc_write: assert property (prescalerClear |-> regWrEn && regAddr == `IWD_TIMER_ADDR)
        else $error("stray prescaler clear");
    a_presc_need: assert property (regWrEn && regAddr == `IWD_TIMER_ADDR && $past(timerPrescAssigned)
        |-> prescalerClear)
        else $error("timer write without prescaler clear");
    a_wdt_q1: assert property (watchdogClear |-> phase == 4'h1 && !regRdEn)
        else $error("watchdog clear out of place");
endmodule : iwd_decoder_sva
bind iwd_decoder iwd_decoder_sva i_iwd_decoder_sva (.clk(clk), .rst(rst),
    .timerPrescAssigned(timerPrescAssigned), .progAddr(progAddr),
    .regAddr(regAddr), .regRdEn(regRdEn), .regWrEn(regWrEn), .pinChangeClear(pinChangeClear),
    .prescalerClear(prescalerClear), .watchdogClear(watchdogClear), .phase(phase));

// ===== iwd_prog_mem.sv
// Program memory model feeding instruction words
`timescale 1ns/1ps
`include "iwd_regs.svh"
module iwd_prog_mem (
    // Fetch side
    input wire logic [`IWD_PC_W-1:0] progAddr,
    output logic [`IWD_WORD_W-1:0]   instrWord
);
    logic [`IWD_WORD_W-1:0] mem [0:2047];
    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = `IWD_NOP_WORD;
        end
    end
    // Whole word shown once the address settles
    assign instrWord = mem[progAddr];
endmodule : iwd_prog_mem

// ===== iwd_decoder_tb_top.sv
// Self-checking testbench for the instruction word decoder
`timescale 1ns/1ps
`include "iwd_regs.svh"
module iwd_decoder_tb_top;
    logic        clk, rst, regRdEn, regWrEn, timerPrescAssigned, d, rdSeen, pccSeen;
    logic        pinChangeClear, prescalerClear, watchdogClear, sleepRequest;
    logic        carry, digitCarry, zero, interruptReturn;
    logic [10:0] progAddr, pc0;
    logic [13:0] instrWord;
    logic [6:0]  regAddr, f;
    logic [7:0]  regRdData, regWrData, wReg, acc, k, rd, e;
    logic [3:0]  phase, op;
    logic [2:0]  b;
    logic [3:0]  ops [4] = '{4'h7, 4'h5, 4'h4, 4'h6};
    int          err_total, checks_done, cycles, seed;
    iwd_prog_mem i_iwd_prog_mem (.progAddr(progAddr), .instrWord(instrWord));
    iwd_decoder i_iwd_decoder (.clk(clk), .rst(rst), .progAddr(progAddr), .instrWord(instrWord),
        .regAddr(regAddr), .regRdEn(regRdEn), .regRdData(regRdData), .regWrEn(regWrEn),
        .regWrData(regWrData), .wReg(wReg), .carry(carry), .digitCarry(digitCarry), .zero(zero),
        .timerPrescAssigned(timerPrescAssigned), .pinChangeClear(pinChangeClear),
        .prescalerClear(prescalerClear), .watchdogClear(watchdogClear),
        .sleepRequest(sleepRequest), .interruptReturn(interruptReturn), .phase(phase));
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    // One instruction from first period to the next first period
    task automatic exec(input logic [13:0] w);
        i_iwd_prog_mem.mem[progAddr] = w;
        regRdData = rd;
        repeat (2) @(negedge clk);
        rdSeen = regRdEn;
        pccSeen = pinChangeClear;
        repeat (2) @(negedge clk);
    endtask : exec
    task automatic bubble();
        repeat (4) begin
            chk("bubble", regRdEn | regWrEn, 0);
            @(negedge clk);
        end
    endtask : bubble
    function automatic logic [7:0] alu(input logic [3:0] o, input logic [7:0] a, input logic [7:0] x);
        case (o)
            4'h7: alu = a + x;
            4'h5: alu = a & x;
            4'h4: alu = a | x;
            default: alu = a ^ x;
        endcase
    endfunction : alu
    // Expected {carry, digit carry} of an 8-bit add
    function automatic logic [1:0] cdc(input logic [7:0] a, input logic [7:0] x);
        cdc = {(9'(a) + 9'(x)) > 9'h0FF, (5'(a[3:0]) + 5'(x[3:0])) > 5'h0F};
    endfunction : cdc
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        rst = 1; rd = 8'h00; regRdData = 8'h00; timerPrescAssigned = 0;
        err_total = 0; checks_done = 0; cycles = 0; seed = 32'h047C;
        repeat (6) @(negedge clk);
        rst = 0;
        k = 8'($random(seed));
        exec({6'b110000, k});
        chk("movlw", wReg, k);
        chk("literal read", rdSeen, 0);
        acc = k;
        k = 8'($random(seed));
        exec({6'b111110, k});
        chk("addlw", wReg, 8'(acc + k));
        chk("addlw flags", {carry, digitCarry}, cdc(acc, k));
        k = 8'hA5;
        exec({6'b110011, k});
        chk("dont care movlw", wReg, k);
        acc = k;
        exec(14'h0060);
        chk("dont care nop", {rdSeen, wReg}, {1'b0, acc});
        $display("test literal done");
        for (int i = 0; i < 12; i++) begin
            op = ops[i % 4]; f = 7'($random(seed)); d = 1'($random(seed)); rd = 8'($random(seed));
            e = alu(op, acc, rd);
            exec({2'b00, op, d, f});
            chk("read pulse", rdSeen, 1);
            chk("file address", regAddr, f);
            chk("write pulse", regWrEn, d);
            if (d) chk("write data", regWrData, e);
            else acc = e;
            chk("accumulator", wReg, acc);
        end
        $display("test byte done");
        rd = 8'hFF;
        exec({7'b0000011, `IWD_PORT_ADDR});
        chk("port read", {rdSeen, pccSeen}, 2'b11);
        chk("clear data", regWrData, 0);
        chk("clear zero", zero, 1);
        for (int i = 0; i < 2; i++) begin
            timerPrescAssigned = 1'(i);
            exec({7'b0000001, `IWD_TIMER_ADDR});
            chk("prescaler clear", prescalerClear, timerPrescAssigned);
            chk("move data", regWrData, acc);
            b = 3'($random(seed)); f = 7'($random(seed)); rd = 8'($random(seed));
            rd[b] = 1'(i); pc0 = progAddr;
            exec({4'b0111, b, f});
            chk("skip address", progAddr, 11'(pc0 + 11'(1 + i)));
            if (i) bubble();
        end
        $display("test file done");
        pc0 = 11'($random(seed));
        exec({3'b101, pc0});
        chk("goto target", progAddr, pc0);
        bubble();
        exec({6'b110000, 8'h3C});
        chk("target ran", wReg, 8'h3C);
        pc0 = progAddr;
        exec({3'b100, 11'h7F0});
        chk("call target", progAddr, 11'h7F0);
        bubble();
        exec(14'h0009);
        chk("return pulse", interruptReturn, 1);
        chk("return address", progAddr, 11'(pc0 + 11'h001));
        bubble();
        exec(14'h0064);
        chk("watchdog clear", watchdogClear, 1);
        exec(14'h0063);
        chk("sleep", sleepRequest, 1);
        $display("test control done");
        tally_and_finish();
    end
endmodule : iwd_decoder_tb_top
